/* File: design/tx_cell_fill_status_counter.v */
// Transmit cell fill pattern, insertion status and sent-cell count for all ports
`timescale 1ns/1ps
`include "tx_cell_consts.vh"
module tx_cell_fill_status_counter #(
   parameter PORTS           = 4,
   parameter [31:0] DEF_HDR  = 32'h00000000,
   parameter [7:0]  DEF_PAY  = 8'h00
) (
   input  wire                   i_core_clk,
   input  wire                   i_rst,
   input  wire                   i_cs,
   input  wire                   i_wr,
   input  wire                   i_rd,
   input  wire [`ADDR_W-1:0]     i_addr,
   input  wire [7:0]             i_wdata,
   output reg  [7:0]             o_rdata,
   input  wire [PORTS-1:0]       i_cell_sent,
   input  wire [PORTS-1:0]       i_err_cell_sent,
   output reg  [PORTS*32-1:0]    o_fill_header,
   output reg  [PORTS*8-1:0]     o_fill_payload,
   output reg  [PORTS-1:0]       o_err_run,
   output reg  [PORTS-1:0]       o_irq
);

   reg  [7:0]  ctrl_q      [0:PORTS-1];
   reg  [7:0]  err_total_q [0:PORTS-1];
   reg  [7:0]  err_ctrl_q  [0:PORTS-1];
   reg  [31:0] hdr_q       [0:PORTS-1];
   reg  [7:0]  pay_q       [0:PORTS-1];
   reg  [7:0]  err_cnt_q   [0:PORTS-1];
   reg  [23:0] cell_cnt_q  [0:PORTS-1];
   reg  [PORTS-1:0] live_q;
   reg  [PORTS-1:0] latch_q;
   reg  [PORTS-1:0] irq_en_q;
   reg  [PORTS-1:0] active_q;

   wire [`ADDR_W-1:0]     norm_addr;
   wire [`PORT_SEL_W-1:0] port_sel;
   wire                   in_window;
   wire                   wr_en;
   integer                p;
   integer                c;
   integer                e;
   integer                l;
   integer                q;

   // Fold every port window onto the port 0 addresses
   assign norm_addr = {i_addr[`ADDR_W-1:`ADDR_W-2], {`PORT_SEL_W{1'b0}}, i_addr[`PORT_STRIDE_SHIFT-1:0]}; // see [RULE12]
   assign port_sel  = i_addr[`PORT_STRIDE_SHIFT+`PORT_SEL_W-1:`PORT_STRIDE_SHIFT]; // see [RULE12]
   assign in_window = (i_addr[`ADDR_W-1:`ADDR_W-2] == `REG_WIN_HI) && (port_sel < PORTS);
   assign wr_en     = i_cs && i_wr && in_window;

   function wr_hit;
      input [`ADDR_W-1:0] off;
      input integer       port;
      begin
         wr_hit = wr_en && (norm_addr == off) && (port_sel == port);
      end
   endfunction

   // Final cell of a finite run; a total of all ones never finishes
   function last_err;
      input [7:0] cnt;
      input [7:0] total;
      begin
         last_err = (cnt + `ERR_ONE == total) && (total != `ERR_CONTINUOUS); // see [RULE5]
      end
   endfunction

   // One-bit flags read back in bit 0, upper bits zero
   function [7:0] flag_byte;
      input flag;
      begin
         flag_byte = {`FLAG_PAD, flag};
      end
   endfunction

   // Software-written configuration per port
   always @(posedge i_core_clk) begin
      for (p = 0; p < PORTS; p = p + 1) begin
         if (i_rst) begin
            ctrl_q[p]      <= `BYTE_ZERO;
            err_total_q[p] <= `BYTE_ZERO;
            hdr_q[p]       <= `HDR_ZERO; // see [RULE1]
            pay_q[p]       <= `BYTE_ZERO;
            irq_en_q[p]    <= 1'b0; // see [RULE8]
         end else begin
            if (wr_hit(`OFF_CELL_CTRL, p)) begin
               ctrl_q[p] <= i_wdata;
            end
            if (wr_hit(`OFF_ERR_TOTAL, p)) begin
               err_total_q[p] <= i_wdata;
            end
            if (wr_hit(`OFF_HDR_B0, p)) begin
               hdr_q[p][`BYTE0_BITS] <= i_wdata; // see [RULE1]
            end
            if (wr_hit(`OFF_HDR_B1, p)) begin
               hdr_q[p][`BYTE1_BITS] <= i_wdata; // see [RULE1]
            end
            if (wr_hit(`OFF_HDR_B2, p)) begin
               hdr_q[p][`BYTE2_BITS] <= i_wdata; // see [RULE1]
            end
            if (wr_hit(`OFF_HDR_B3, p)) begin
               hdr_q[p][`BYTE3_BITS] <= i_wdata; // see [RULE1]
            end
            if (wr_hit(`OFF_FILL_PAY, p)) begin
               pay_q[p] <= i_wdata;
            end
            // Only bit 0 is stored; upper bits must be written as zero
            if (wr_hit(`OFF_IRQ_EN, p)) begin
               irq_en_q[p] <= i_wdata[`DONE_BIT]; // see [RULE8]
            end
         end
      end
   end

   // Counter wraps silently; three byte reads are no snapshot
   always @(posedge i_core_clk) begin
      for (c = 0; c < PORTS; c = c + 1) begin
         if (i_rst) begin
            cell_cnt_q[c] <= `CNT_ZERO;
         end else if (i_cell_sent[c]) begin
            cell_cnt_q[c] <= cell_cnt_q[c] + `CNT_ONE; // see [RULE10]
         end
      end
   end

   // A rate write ends any run, starts a new one for a non-zero rate and non-zero total, and restarts the count from zero
   always @(posedge i_core_clk) begin
      for (e = 0; e < PORTS; e = e + 1) begin
         if (i_rst) begin
            err_ctrl_q[e] <= `BYTE_ZERO;
            err_cnt_q[e]  <= `BYTE_ZERO;
            live_q[e]     <= 1'b0;
            active_q[e]   <= 1'b0;
         end else if (wr_hit(`OFF_ERR_CTRL, e)) begin
            err_ctrl_q[e] <= i_wdata;
            err_cnt_q[e]  <= `BYTE_ZERO;
            live_q[e]     <= 1'b0; // see [RULE6]
            // Total of zero starts nothing, so no run of none
            active_q[e]   <= (i_wdata[`RATE_X_HI:`RATE_X_LO] != `RATE_X_ZERO) &&
                             (err_total_q[e] != `BYTE_ZERO); // see [RULE4]
         end else if (active_q[e] && i_err_cell_sent[e]) begin
            err_cnt_q[e] <= err_cnt_q[e] + `ERR_ONE;
            if (last_err(err_cnt_q[e], err_total_q[e])) begin
               active_q[e] <= 1'b0; // see [RULE4]
               live_q[e]   <= 1'b1; // see [RULE5]
            end
         end
      end
   end

   // Edge taken from the set condition of live, so no extra delay
   // Rising edge of live wins over a same-cycle write-one clear
   always @(posedge i_core_clk) begin
      for (l = 0; l < PORTS; l = l + 1) begin
         if (i_rst) begin
            latch_q[l] <= 1'b0;
         end else begin
            latch_q[l] <= (latch_q[l] && !(wr_hit(`OFF_STATUS_LATCH, l) && i_wdata[`DONE_BIT])) ||
                          (active_q[l] && i_err_cell_sent[l] && !wr_hit(`OFF_ERR_CTRL, l) &&
                           last_err(err_cnt_q[l], err_total_q[l]) && !live_q[l]); // see [RULE7]
         end
      end
   end

   // Outputs to the transmit path, all registered
   always @(posedge i_core_clk) begin
      for (q = 0; q < PORTS; q = q + 1) begin
         if (i_rst) begin
            o_fill_header[q*32 +: 32] <= DEF_HDR;
            o_fill_payload[q*8 +: 8]  <= DEF_PAY;
            o_err_run[q]              <= 1'b0;
            o_irq[q]                  <= 1'b0;
         end else begin
            o_fill_header[q*32 +: 32] <= ctrl_q[q][`CTRL_HDR_SEL_BIT] ? hdr_q[q] : DEF_HDR; // see [RULE2]
            o_fill_payload[q*8 +: 8]  <= ctrl_q[q][`CTRL_PAY_SEL_BIT] ? pay_q[q] : DEF_PAY; // see [RULE3]
            o_err_run[q]              <= active_q[q];
            o_irq[q]                  <= latch_q[q] && irq_en_q[q]; // see [RULE8]
         end
      end
   end

   // Read port, one cycle latency; unmapped addresses read zero
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_rdata <= `BYTE_ZERO;
      end else if (i_cs && i_rd && in_window) begin
         if (norm_addr == `OFF_CELL_CTRL) begin
            o_rdata <= ctrl_q[port_sel];
         end else if (norm_addr == `OFF_ERR_TOTAL) begin
            o_rdata <= err_total_q[port_sel];
         end else if (norm_addr == `OFF_ERR_CTRL) begin
            o_rdata <= err_ctrl_q[port_sel];
         end else if (norm_addr == `OFF_HDR_B0) begin
            o_rdata <= hdr_q[port_sel][`BYTE0_BITS];
         end else if (norm_addr == `OFF_HDR_B1) begin
            o_rdata <= hdr_q[port_sel][`BYTE1_BITS];
         end else if (norm_addr == `OFF_HDR_B2) begin
            o_rdata <= hdr_q[port_sel][`BYTE2_BITS];
         end else if (norm_addr == `OFF_HDR_B3) begin
            o_rdata <= hdr_q[port_sel][`BYTE3_BITS];
         end else if (norm_addr == `OFF_FILL_PAY) begin
            o_rdata <= pay_q[port_sel];
         end else if (norm_addr == `OFF_STATUS) begin
            o_rdata <= flag_byte(live_q[port_sel]); // see [RULE5]
         end else if (norm_addr == `OFF_STATUS_LATCH) begin
            o_rdata <= flag_byte(latch_q[port_sel]); // see [RULE7]
         end else if (norm_addr == `OFF_IRQ_EN) begin
            o_rdata <= flag_byte(irq_en_q[port_sel]);
         end else if (norm_addr == `OFF_CNT_LOW) begin
            o_rdata <= cell_cnt_q[port_sel][`BYTE0_BITS]; // see [RULE11]
         end else if (norm_addr == `OFF_CNT_MID) begin
            o_rdata <= cell_cnt_q[port_sel][`BYTE1_BITS]; // see [RULE11]
         end else if (norm_addr == `OFF_CNT_HIGH) begin
            o_rdata <= cell_cnt_q[port_sel][`BYTE2_BITS]; // see [RULE11]
         end else begin
            o_rdata <= `BYTE_ZERO;
         end
      end else begin
         o_rdata <= `BYTE_ZERO;
      end
   end

endmodule

/* File: shared/tx_cell_consts.vh */
// Constants for the transmit cell fill, status and count block
// What this block does
// [RULE1] Four byte registers hold a 32-bit fill header pattern, reset to zero.
// [RULE2] Fill header select set: fill cells carry the programmed 32-bit header.
// [RULE3] Fill payload select set: every fill payload byte is the programmed value.
// [RULE4] Writing a non-zero error rate starts a run; ends after the programmed total, never for a total of FFh. The code starts no run while the total is zero.
// [RULE5] Live finished flag bit 0 sets when the programmed errored cells are sent.
// [RULE6] Live finished flag clears on insertion disable or on a new run.
// [RULE7] Latched finished bit 0 sets on a zero-to-one edge of the live flag.
// [RULE8] Interrupt requested while latched bit and its enable are both 1.
// [RULE9] Software writes zero to bits 7 to 1 of the interrupt enable register.
// [RULE10] A 24-bit counter counts every cell taken from the FIFO and sent.
// [RULE11] Cell count read as three bytes, low byte at the lowest address.
// [RULE12] Register set repeats per port at offsets 200h, 400h and 600h.
`ifndef TX_CELL_CONSTS_VH
`define TX_CELL_CONSTS_VH

`define ADDR_W            13
`define PORT_STRIDE_SHIFT 9
`define PORT_SEL_W        2
`define REG_WIN_HI        2'h2

`define OFF_CELL_CTRL     13'h1101
`define OFF_ERR_TOTAL     13'h1104
`define OFF_ERR_CTRL      13'h1105
`define OFF_HDR_B0        13'h1108
`define OFF_HDR_B1        13'h1109
`define OFF_HDR_B2        13'h110A
`define OFF_HDR_B3        13'h110B
`define OFF_FILL_PAY      13'h110C
`define OFF_STATUS        13'h110E
`define OFF_STATUS_LATCH  13'h1110
`define OFF_IRQ_EN        13'h1112
`define OFF_CNT_LOW       13'h1114
`define OFF_CNT_MID       13'h1115
`define OFF_CNT_HIGH      13'h1116

`define CTRL_HDR_SEL_BIT  0
`define CTRL_PAY_SEL_BIT  1
`define RATE_X_HI         3
`define RATE_X_LO         0
`define DONE_BIT          0
`define ERR_CONTINUOUS    8'hFF
`define BYTE_ZERO         8'h00
`define CNT_ZERO          24'h000000
`define CNT_ONE           24'h000001
`define ERR_ONE           8'h01
`define RATE_X_ZERO       4'h0
`define FLAG_PAD          7'h00
`define HDR_ZERO          32'h00000000
`define BYTE0_BITS        7:0
`define BYTE1_BITS        15:8
`define BYTE2_BITS        23:16
`define BYTE3_BITS        31:24

`endif

/* File: testbench/tx_cell_fill_status_counter_monitor.sv */
// Port-level checker for the cell fill, status and count block
`timescale 1ns/1ps
module tx_cell_fill_status_counter_monitor #(parameter PORTS = 4) (
   input wire                i_core_clk,
   input wire                i_rst,
   input wire                i_cs,
   input wire                i_wr,
   input wire                i_rd,
   input wire [12:0]         i_addr,
   input wire [7:0]          i_wdata,
   input wire [7:0]          o_rdata,
   input wire [PORTS*32-1:0] o_fill_header,
   input wire [PORTS*8-1:0]  o_fill_payload,
   input wire [PORTS-1:0]    o_err_run,
   input wire [PORTS-1:0]    o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   wire wr = i_cs && i_wr;
   wire rd = i_cs && i_rd;
   AST_RD_IDLE: assert property (!rd |=> o_rdata == 8'h00)
      else $error("read data not idle");
   AST_RUN_OFF: assert property (wr && i_addr == 13'h1105 && i_wdata[3:0] == 4'h0 |-> ##2 !o_err_run[0])
      else $error("run not stopped");
   AST_RUN_RISE: assert property ($rose(o_err_run[0]) |-> $past(wr && i_addr == 13'h1105, 2))
      else $error("run rose without start");
   AST_IRQ_MASK: assert property (wr && i_addr == 13'h1112 && !i_wdata[0] |-> ##2 !o_irq[0])
      else $error("irq not masked");
   // Enable write or run end are the only ways up
   AST_IRQ_RISE: assert property ($rose(o_irq[0]) |-> $past(o_err_run[0]) || $past(wr && i_addr == 13'h1112, 2))
      else $error("irq rose without cause");
   AST_HDR_CHG: assert property (!$stable(o_fill_header) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("header moved without write");
   AST_PAY_CHG: assert property (!$stable(o_fill_payload) |-> $past(wr) || $past(wr, 2) || $past(wr, 3))
      else $error("payload moved without write");
   AST_STAT_BITS: assert property (rd && (i_addr == 13'h110E || i_addr == 13'h1110) |=> o_rdata[7:1] == 7'h00)
      else $error("unused status bits set");
endmodule
bind tx_cell_fill_status_counter tx_cell_fill_status_counter_monitor #(.PORTS(PORTS)) mon (.i_core_clk(i_core_clk),
   .i_rst(i_rst), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_fill_header(o_fill_header), .o_fill_payload(o_fill_payload), .o_err_run(o_err_run), .o_irq(o_irq));

/* File: testbench/tx_path_model.sv */
// Transmit data path model that reports sent cells
`timescale 1ns/1ps
module tx_path_model (
   input  wire       i_core_clk,
   output reg  [3:0] o_cell,
   output reg  [3:0] o_err
);
   initial {o_cell, o_err} = 8'h00;
   // Gap of zero holds the pulse high for back-to-back cells
   task send(input int p, input int n, input bit e, input int gap);
      repeat (n) begin
         @(negedge i_core_clk);
         {o_cell[p], o_err[p]} = {1'b1, e};
         repeat (gap) begin
            @(negedge i_core_clk);
            {o_cell[p], o_err[p]} = 2'b00;
         end
      end
      @(negedge i_core_clk);
      {o_cell[p], o_err[p]} = 2'b00;
   endtask
endmodule

/* File: testbench/tx_cell_fill_status_counter_bench.sv */
// Self-checking bench for the cell fill, status and count block
`timescale 1ns/1ps
module tx_cell_fill_status_counter_bench;
   logic i_core_clk = 1'b0, i_rst = 1'b1, i_cs = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [12:0] i_addr = 13'h0000;
   logic [7:0] i_wdata = 8'h00, o_rdata;
   logic [3:0] i_cell_sent, i_err_cell_sent, o_err_run, o_irq;
   logic [127:0] o_fill_header;
   logic [31:0] o_fill_payload;
   int err_total = 0, tests_run = 0, cyc = 0;
   always #2.5 i_core_clk = ~i_core_clk;
   tx_cell_fill_status_counter dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd),
      .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cell_sent(i_cell_sent),
      .i_err_cell_sent(i_err_cell_sent), .o_fill_header(o_fill_header), .o_fill_payload(o_fill_payload),
      .o_err_run(o_err_run), .o_irq(o_irq));
   tx_path_model far (.i_core_clk(i_core_clk), .o_cell(i_cell_sent), .o_err(i_err_cell_sent));
   task end_sim;
      if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [12:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      {i_cs, i_wr, i_addr, i_wdata} = {2'b11, a, d};
      @(negedge i_core_clk);
      {i_cs, i_wr} = 2'b00;
   endtask
   // Data sampled a half cycle after the taking edge
   task rd(input logic [12:0] a, input logic [7:0] e);
      @(negedge i_core_clk);
      {i_cs, i_rd, i_addr} = {2'b11, a};
      @(negedge i_core_clk);
      {i_cs, i_rd} = 2'b00;
      chk(o_rdata, e);
   endtask
   always @(posedge i_core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         end_sim;
      end
   end
   task t_reset;
      int i;
      for (i = 0; i < 23; i++) rd(13'h1100 + i[12:0], 8'h00);
   endtask
   task t_fill;
      int i;
      for (i = 0; i < 4; i++) wr(13'h1308 + i[12:0], 8'hA0 + i[7:0]);
      wr(13'h130C, 8'h5A);
      wr(13'h1301, 8'h03);
      repeat (3) @(negedge i_core_clk);
      chk(o_fill_header[63:32], 32'hA3A2A1A0);
      chk(o_fill_payload[15:8], 8'h5A);
      chk(o_fill_header[31:0], 32'h00000000);
      rd(13'h130A, 8'hA2);
   endtask
   task t_count;
      far.send(2, 3, 1'b0, 1);
      far.send(2, 2, 1'b0, 0);
      rd(13'h1514, 8'h05);
      rd(13'h1515, 8'h00);
      rd(13'h1516, 8'h00);
      rd(13'h1114, 8'h00);
      far.send(1, 256, 1'b0, 0);
      rd(13'h1314, 8'h00);
      rd(13'h1315, 8'h01);
   endtask
   task t_err;
      wr(13'h1104, 8'h02);
      wr(13'h1112, 8'h01);
      wr(13'h1105, 8'h01);
      repeat (2) @(negedge i_core_clk);
      chk(o_err_run[0], 1'b1);
      rd(13'h110E, 8'h00);
      far.send(0, 2, 1'b1, 0);
      repeat (3) @(negedge i_core_clk);
      chk(o_irq[0], 1'b1);
      chk(o_err_run[0], 1'b0);
      rd(13'h110E, 8'h01);
      rd(13'h1110, 8'h01);
      wr(13'h1112, 8'h00);
      @(negedge i_core_clk);
      chk(o_irq[0], 1'b0);
      wr(13'h1105, 8'h00);
      rd(13'h110E, 8'h00);
      rd(13'h1110, 8'h01);
   endtask
   // Latch clear, restart, endless total and empty total on port 0
   task t_flags;
      wr(13'h1110, 8'h01);
      rd(13'h1110, 8'h00);
      wr(13'h1105, 8'h01);
      far.send(0, 2, 1'b1, 0);
      rd(13'h110E, 8'h01);
      rd(13'h1110, 8'h01);
      wr(13'h1105, 8'h01);
      rd(13'h110E, 8'h00);
      chk(o_err_run[0], 1'b1);
      wr(13'h1104, 8'hFF);
      wr(13'h1105, 8'h01);
      far.send(0, 3, 1'b1, 0);
      chk(o_err_run[0], 1'b1);
      rd(13'h110E, 8'h00);
      wr(13'h1105, 8'h00);
      wr(13'h1104, 8'h00);
      wr(13'h1105, 8'h01);
      repeat (2) @(negedge i_core_clk);
      chk(o_err_run[0], 1'b0);
      rd(13'h110E, 8'h00);
      rd(13'h1114, 8'h07);
   endtask
   // Reset with no run active, held three edges
   task t_mid_reset;
      @(negedge i_core_clk);
      i_rst = 1'b1;
      repeat (3) @(negedge i_core_clk);
      i_rst = 1'b0;
      chk(o_fill_header[63:32], 32'h00000000);
      rd(13'h1309, 8'h00);
      rd(13'h1314, 8'h00);
      rd(13'h1110, 8'h00);
   endtask
   initial begin
      repeat (5) @(negedge i_core_clk);
      i_rst = 1'b0;
      t_reset;
      t_fill;
      t_count;
      t_err;
      t_flags;
      t_mid_reset;
      end_sim;
   end
endmodule
